// ---- hw/iqpf_edge_det.v ----
// Purpose: Pin synchroniser and selectable edge detector
// Assumes: Pin is asynchronous to i_clk
// Notes:   Change counts once second and third stages agree
`timescale 1ns/100ps
`default_nettype none
module iqpf_edge_det (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst_b,
  // Pin and select
  input  wire i_pin,
  input  wire i_rise_sel,
  // Event
  output reg  o_edge
);
  reg  [2:0] sync_q;
  reg  [1:0] fill_q;
  reg        level_q;
  wire       agree;

  assign agree = (sync_q[1] == sync_q[2]);

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_q  <= 3'h0;
      fill_q  <= 2'h0;
      level_q <= 1'b0;
      o_edge  <= 1'b0;
    end else begin
      sync_q  <= {sync_q[1:0], i_pin};
      o_edge  <= 1'b0;
      if (fill_q != 2'h3) begin
        // Pipeline still filling: seed the level so an idle-high pin is no edge
        fill_q  <= fill_q + 2'h1;
        level_q <= sync_q[1];
      end else if (agree && (sync_q[2] != level_q)) begin
        level_q <= sync_q[2];
        o_edge  <= (sync_q[2] == i_rise_sel);
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/iqpf_map.vh ----
// Purpose: Register offsets, field positions and reset values for the interrupt flag block
// Assumes: 32-bit APB, one register per aligned word
// Notes:   Offsets and the vector register layout are local choices
`ifndef IQPF_MAP_VH
`define IQPF_MAP_VH

`define IQPF_OFS_EDGE     12'h000
`define IQPF_OFS_EXTPIN   12'h004
`define IQPF_OFS_PIRA     12'h008
`define IQPF_OFS_CORE     12'h00c
`define IQPF_OFS_VECT     12'h010

`define IQPF_EDGE_RST     8'hf5
`define IQPF_EDGE_MASK    8'hf5
`define IQPF_EXTPIN_RST   8'hc0
`define IQPF_EXTPIN_MASK  8'hdb
`define IQPF_CORE_RST     5'h10

`define IQPF_B_PULLUP     7
`define IQPF_B_EDGE0      6
`define IQPF_B_EDGE1      5
`define IQPF_B_EDGE2      4
`define IQPF_B_T0PRIO     2
`define IQPF_B_PCPRIO     0

`define IQPF_B_EXT2PRIO   7
`define IQPF_B_EXT1PRIO   6
`define IQPF_B_EXT2EN     4
`define IQPF_B_EXT1EN     3
`define IQPF_B_EXT2FLAG   1
`define IQPF_B_EXT1FLAG   0

`define IQPF_B_PAR        7
`define IQPF_B_CONV       6
`define IQPF_B_RX         5
`define IQPF_B_TX         4
`define IQPF_B_SSP        3
`define IQPF_B_CCP        2
`define IQPF_B_TIMER2_COUNT       1
`define IQPF_B_TIMER1_COUNT       0

`define IQPF_B_GIE        0
`define IQPF_B_GIEL       1
`define IQPF_B_PRIOMODE   2
`define IQPF_B_PEIE       3
`define IQPF_B_HASPAR     4

`define IQPF_VEC_HIGH     16'h0008
`define IQPF_VEC_LOW      16'h0018

`define IQPF_CCP_CAPTURE  2'h0
`define IQPF_CCP_COMPARE  2'h1
`define IQPF_CCP_PWM      2'h2

`endif

// ---- hw/iqpf_regs.v ----
// Purpose: Edge-select/priority, external pin and peripheral flag registers with vectoring
// Assumes: APB slave, zero wait states, peripherals give one-cycle event pulses
// Notes:   Enables/priorities of peripherals live elsewhere; they come in as levels
//
// Functional notes
// - Unimplemented bits of edge and pin registers read zero, ignore writes
// - Port-change priority bit: one high, zero low, resets to one
// - Pin 2 priority at bit 7, one high, resets to one
// - Pin 1 priority at bit 6, one high, resets to one
// - Pin 2 enable gates its request, resets to zero
// - Pin 1 enable gates its request, resets to zero
// - Pin 2 flag set on selected edge, cleared by software zero write
// - Pin 1 flag set on selected edge, cleared by software zero write
// - Flags set regardless of enables so software can poll
// - Parallel-port flag set on external port access, software clears
// - Parallel-port flag reads zero on variant without the port
// - Converter flag set on conversion done, software clears, resets zero
// - Receive flag read-only, follows receive buffer full
// - Transmit flag read-only, follows transmit buffer empty
// - Sync serial flag set on transfer done, software clears
// - Capture mode: capture sets unit-1 flag, software clears
// - Compare mode: match sets unit-1 flag; unused in pulse-width mode
// - Timer-2 flag set on period match, software clears
// - Priority mode: high source vectors high address, low to low
// - Priority mode off: priority bits ignored for vectoring
// - Taking an interrupt clears the applicable global enable
`timescale 1ns/100ps
`default_nettype none
`include "iqpf_map.vh"
module iqpf_regs (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_b,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // External pins
  input  wire        i_ext1_pin,
  input  wire        i_ext2_pin,
  // Peripheral events and levels
  input  wire        i_par_port_access,
  input  wire        i_conv_done,
  input  wire        i_rx_full,
  input  wire        i_tx_empty,
  input  wire        i_sync_serial_done,
  input  wire [1:0]  i_capcmp1_mode,
  input  wire        i_capcmp1_capture,
  input  wire        i_capcmp1_match,
  input  wire        i_timer2_match,
  input  wire        i_timer1_ovf,
  input  wire [7:0]  i_periph_en,
  input  wire [7:0]  i_periph_prio,
  // Core sequencer
  input  wire        i_irq_ack,
  output reg         o_irq_req,
  output reg  [15:0] o_irq_vector,
  output reg         o_pullup_disable,
  output reg  [2:0]  o_edge_sel,
  output reg         o_timer0_ovf_prio,
  output reg         o_port_change_prio
);
  reg  [7:0]  edge_q;
  reg  [7:0]  extpin_q;
  reg  [7:0]  pira_q;
  reg  [4:0]  core_q;
  reg  [7:0]  pira_d;
  reg  [7:0]  extpin_d;
  reg  [4:0]  core_d;
  reg  [31:0] rdata_d;
  reg  [7:0]  pira_rd;
  reg         hi_pend;
  reg         lo_pend;
  wire        ext1_edge;
  wire        ext2_edge;
  wire        wr_en;
  wire        rd_en;
  wire        take;

  // Write lands at the edge that completes the access, not at setup
  assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
  assign rd_en = i_psel && !i_penable && !i_pwrite;

  function hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Sticky flag: an event in the clearing cycle wins
  function sticky;
    input cur;
    input ev;
    input wr;
    input wbit;
    begin
      sticky = ev | (wr ? (cur & wbit) : cur);
    end
  endfunction

  iqpf_edge_det u_ext1 (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_pin      (i_ext1_pin),
    .i_rise_sel (edge_q[`IQPF_B_EDGE1]),
    .o_edge     (ext1_edge)
  );

  iqpf_edge_det u_ext2 (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_pin      (i_ext2_pin),
    .i_rise_sel (edge_q[`IQPF_B_EDGE2]),
    .o_edge     (ext2_edge)
  );

  // Flag and control next values
  always @* begin
    extpin_d = extpin_q;
    if (wr_en && hit(i_paddr, `IQPF_OFS_EXTPIN)) begin
      extpin_d = i_pwdata[7:0] & `IQPF_EXTPIN_MASK;
    end
    // Flags rise regardless of any enable
    extpin_d[`IQPF_B_EXT1FLAG] = sticky(extpin_q[`IQPF_B_EXT1FLAG], ext1_edge,
      wr_en && hit(i_paddr, `IQPF_OFS_EXTPIN), i_pwdata[`IQPF_B_EXT1FLAG]);
    extpin_d[`IQPF_B_EXT2FLAG] = sticky(extpin_q[`IQPF_B_EXT2FLAG], ext2_edge,
      wr_en && hit(i_paddr, `IQPF_OFS_EXTPIN), i_pwdata[`IQPF_B_EXT2FLAG]);

    pira_d = pira_q;
    pira_d[`IQPF_B_PAR] = core_q[`IQPF_B_HASPAR] && sticky(pira_q[`IQPF_B_PAR],
      i_par_port_access, wr_en && hit(i_paddr, `IQPF_OFS_PIRA), i_pwdata[`IQPF_B_PAR]);
    pira_d[`IQPF_B_CONV] = sticky(pira_q[`IQPF_B_CONV], i_conv_done,
      wr_en && hit(i_paddr, `IQPF_OFS_PIRA), i_pwdata[`IQPF_B_CONV]);
    pira_d[`IQPF_B_SSP] = sticky(pira_q[`IQPF_B_SSP], i_sync_serial_done,
      wr_en && hit(i_paddr, `IQPF_OFS_PIRA), i_pwdata[`IQPF_B_SSP]);
    pira_d[`IQPF_B_CCP] = sticky(pira_q[`IQPF_B_CCP],
      ((i_capcmp1_mode == `IQPF_CCP_CAPTURE) && i_capcmp1_capture) ||
      ((i_capcmp1_mode == `IQPF_CCP_COMPARE) && i_capcmp1_match),
      wr_en && hit(i_paddr, `IQPF_OFS_PIRA), i_pwdata[`IQPF_B_CCP]);
    pira_d[`IQPF_B_TIMER2_COUNT] = sticky(pira_q[`IQPF_B_TIMER2_COUNT], i_timer2_match,
      wr_en && hit(i_paddr, `IQPF_OFS_PIRA), i_pwdata[`IQPF_B_TIMER2_COUNT]);
    pira_d[`IQPF_B_TIMER1_COUNT] = sticky(pira_q[`IQPF_B_TIMER1_COUNT], i_timer1_ovf,
      wr_en && hit(i_paddr, `IQPF_OFS_PIRA), i_pwdata[`IQPF_B_TIMER1_COUNT]);
    // Status bits mirror the serial buffers, writes have no effect
    pira_d[`IQPF_B_RX] = i_rx_full;
    pira_d[`IQPF_B_TX] = i_tx_empty;
  end

  // Pending requests by level
  always @* begin
    hi_pend = 1'b0;
    lo_pend = 1'b0;
    if (extpin_q[`IQPF_B_EXT1FLAG] && extpin_q[`IQPF_B_EXT1EN]) begin
      if (extpin_q[`IQPF_B_EXT1PRIO]) begin
        hi_pend = 1'b1;
      end else begin
        lo_pend = 1'b1;
      end
    end
    if (extpin_q[`IQPF_B_EXT2FLAG] && extpin_q[`IQPF_B_EXT2EN]) begin
      if (extpin_q[`IQPF_B_EXT2PRIO]) begin
        hi_pend = 1'b1;
      end else begin
        lo_pend = 1'b1;
      end
    end
    // Peripherals also need the peripheral enable outside priority mode
    if (|(pira_q & i_periph_en & i_periph_prio) &&
        (core_q[`IQPF_B_PRIOMODE] || core_q[`IQPF_B_PEIE])) begin
      hi_pend = 1'b1;
    end
    if (|(pira_q & i_periph_en & ~i_periph_prio) &&
        (core_q[`IQPF_B_PRIOMODE] || core_q[`IQPF_B_PEIE])) begin
      lo_pend = 1'b1;
    end
    if (!core_q[`IQPF_B_PRIOMODE]) begin
      hi_pend = (hi_pend || lo_pend) && core_q[`IQPF_B_GIE];
      lo_pend = 1'b0;
    end else begin
      hi_pend = hi_pend && core_q[`IQPF_B_GIE];
      lo_pend = lo_pend && core_q[`IQPF_B_GIEL] && core_q[`IQPF_B_GIE];
    end
  end

  assign take = i_irq_ack && o_irq_req;

  always @* begin
    core_d = core_q;
    if (wr_en && hit(i_paddr, `IQPF_OFS_CORE)) begin
      core_d = i_pwdata[4:0];
    end
    if (take) begin
      // High level or compatibility mode uses the main enable
      if (o_irq_vector == `IQPF_VEC_HIGH) begin
        core_d[`IQPF_B_GIE] = 1'b0;
      end else begin
        core_d[`IQPF_B_GIEL] = 1'b0;
      end
    end
  end

  always @* begin
    pira_rd = pira_q;
    pira_rd[`IQPF_B_PAR] = pira_q[`IQPF_B_PAR] & core_q[`IQPF_B_HASPAR];
    rdata_d = 32'h0;
    if (rd_en) begin
      if (hit(i_paddr, `IQPF_OFS_EDGE)) begin
        rdata_d = {24'h0, edge_q & `IQPF_EDGE_MASK};
      end else if (hit(i_paddr, `IQPF_OFS_EXTPIN)) begin
        rdata_d = {24'h0, extpin_q & `IQPF_EXTPIN_MASK};
      end else if (hit(i_paddr, `IQPF_OFS_PIRA)) begin
        rdata_d = {24'h0, pira_rd};
      end else if (hit(i_paddr, `IQPF_OFS_CORE)) begin
        rdata_d = {27'h0, core_q};
      end else if (hit(i_paddr, `IQPF_OFS_VECT)) begin
        rdata_d = {15'h0, o_irq_req, o_irq_vector};
      end
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      edge_q             <= `IQPF_EDGE_RST;
      extpin_q           <= `IQPF_EXTPIN_RST;
      pira_q             <= 8'h00;
      core_q             <= `IQPF_CORE_RST;
      o_prdata           <= 32'h0;
      o_pready           <= 1'b0;
      o_pslverr          <= 1'b0;
      o_irq_req          <= 1'b0;
      o_irq_vector       <= `IQPF_VEC_HIGH;
      o_pullup_disable   <= 1'b1;
      o_edge_sel         <= 3'h7;
      o_timer0_ovf_prio  <= 1'b1;
      o_port_change_prio <= 1'b1;
    end else begin
      if (wr_en && hit(i_paddr, `IQPF_OFS_EDGE)) begin
        edge_q <= i_pwdata[7:0] & `IQPF_EDGE_MASK;
      end
      extpin_q  <= extpin_d;
      pira_q    <= pira_d;
      core_q    <= core_d;
      // Answer in the access phase; setup strobes keep it one cycle
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable) begin
        o_prdata <= rdata_d;
      end
      o_pullup_disable   <= edge_q[`IQPF_B_PULLUP];
      o_edge_sel         <= {edge_q[`IQPF_B_EDGE2], edge_q[`IQPF_B_EDGE1], edge_q[`IQPF_B_EDGE0]};
      o_timer0_ovf_prio  <= edge_q[`IQPF_B_T0PRIO];
      o_port_change_prio <= edge_q[`IQPF_B_PCPRIO];
      o_irq_req          <= (hi_pend || lo_pend) && !take;
      if (hi_pend) begin
        o_irq_vector <= `IQPF_VEC_HIGH;
      end else if (lo_pend) begin
        o_irq_vector <= `IQPF_VEC_LOW;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/iqpf_core_model.sv ----
// Purpose: Core sequencer that takes interrupt requests
// Assumes: Request is a level, acknowledge a one-cycle pulse
// Notes:   DLY sets how slowly the core responds
`timescale 1ns/100ps
`default_nettype none
module iqpf_core_model #(parameter int DLY = 3) (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // Request from the block
  input wire logic        i_irq_req,
  input wire logic [15:0] i_irq_vector,
  // Acknowledge and record
  output logic            o_irq_ack,
  output logic [15:0]     o_taken_vec,
  output logic [7:0]      o_taken_cnt
);
  int wait_q;
  // Counter restarts after ack so a lingering request is not taken twice
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq_ack <= 1'b0;
      o_taken_vec <= 16'h0;
      o_taken_cnt <= 8'h0;
      wait_q <= 0;
    end else begin
      o_irq_ack <= 1'b0;
      if (!i_irq_req || o_irq_ack) begin
        wait_q <= 0;
      end else if (wait_q == DLY) begin
        o_irq_ack <= 1'b1;
        o_taken_vec <= i_irq_vector;
        o_taken_cnt <= o_taken_cnt + 8'h1;
        wait_q <= 0;
      end else begin
        wait_q <= wait_q + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/iqpf_regs_properties.sv ----
// Purpose: Port-level assertions for the interrupt flag block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Attached by the bind below
`timescale 1ns/100ps
`default_nettype none
module iqpf_regs_properties (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Core side
  input wire logic        i_irq_ack,
  input wire logic        o_irq_req,
  input wire logic [15:0] o_irq_vector,
  input wire logic [2:0]  o_edge_sel,
  input wire logic        o_pullup_disable,
  input wire logic        o_port_change_prio,
  input wire logic        o_timer0_ovf_prio
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  answer_next_a: assert property (i_psel && !i_penable |=> o_pready && !o_pslverr)
    else $error("no single-cycle answer");
  ready_in_access_a: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  unmapped_zero_a: assert property (i_psel && !i_penable && !i_pwrite && i_paddr > 12'h010
    |=> o_prdata == 32'h0) else $error("unmapped read not zero");
  upper_zero_a: assert property (o_pready && i_paddr != 12'h010 |-> o_prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  edge_mirror_a: assert property (i_psel && i_penable && i_pwrite && o_pready
    && i_paddr == 12'h000 |-> ##2 o_port_change_prio == $past(i_pwdata[0], 2)
    && o_timer0_ovf_prio == $past(i_pwdata[2], 2)
    && o_pullup_disable == $past(i_pwdata[7], 2)
    && o_edge_sel == $past({i_pwdata[4], i_pwdata[5], i_pwdata[6]}, 2))
    else $error("edge register outputs wrong");
  reset_values_a: assert property ($rose(i_rst_b) |-> o_pullup_disable && !o_irq_req
    && o_edge_sel == 3'h7 && o_port_change_prio && o_timer0_ovf_prio)
    else $error("reset outputs wrong");
  ack_drop_a: assert property (i_irq_ack && o_irq_req |-> ##[1:2] !o_irq_req)
    else $error("request stays after ack");
  vector_legal_a: assert property (o_irq_req |-> o_irq_vector == 16'h0008 || o_irq_vector == 16'h0018)
    else $error("vector not a legal address");
endmodule
bind iqpf_regs iqpf_regs_properties u_iqpf_regs_properties (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_irq_ack(i_irq_ack), .o_irq_req(o_irq_req),
  .o_irq_vector(o_irq_vector), .o_edge_sel(o_edge_sel), .o_pullup_disable(o_pullup_disable),
  .o_port_change_prio(o_port_change_prio), .o_timer0_ovf_prio(o_timer0_ovf_prio));
`default_nettype wire

// ---- tb/irq_priority_flag_regs_test.sv ----
// Purpose: Register, flag and vectoring checks over APB
// Assumes: Zero-wait slave, pins settle 3 cycles after reset
// Notes:   Pins, events and peripheral enables drive flags and requests
`timescale 1ns/100ps
`default_nettype none
`include "iqpf_map.vh"
module irq_priority_flag_regs_test;
  logic        i_clk, i_rst_b, psel, penable, pwrite, pready, pin1, pin2, rx, tx, req, ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] vec, tvec;
  logic [7:0]  tcnt, pen, ppri;
  logic [6:0]  ev;
  logic [1:0]  mode;
  logic [7:0]  fexp [0:6] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h40, 8'h80};
  int          error_cnt, checked;

  iqpf_regs u_iqpf_regs (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(), .i_ext1_pin(pin1), .i_ext2_pin(pin2), .i_par_port_access(ev[6]),
    .i_conv_done(ev[5]), .i_rx_full(rx), .i_tx_empty(tx), .i_sync_serial_done(ev[4]),
    .i_capcmp1_mode(mode), .i_capcmp1_capture(ev[3]), .i_capcmp1_match(ev[2]),
    .i_timer2_match(ev[1]), .i_timer1_ovf(ev[0]), .i_periph_en(pen), .i_periph_prio(ppri),
    .i_irq_ack(ack), .o_irq_req(req), .o_irq_vector(vec), .o_pullup_disable(), .o_edge_sel(),
    .o_timer0_ovf_prio(), .o_port_change_prio());
  iqpf_core_model #(.DLY(3)) u_iqpf_core_model (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_irq_req(req), .i_irq_vector(vec), .o_irq_ack(ack), .o_taken_vec(tvec), .o_taken_cnt(tcnt));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task close_out;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out;
    end
  endtask

  task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(n, e, q);
  endtask

  task pulse(input int i);
    @(posedge i_clk);
    ev[i] <= 1'b1;
    @(posedge i_clk);
    ev <= 7'h00;
  endtask

  task await_take(input logic [7:0] k);
    int n;
    n = 0;
    while (tcnt !== k && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    if (tcnt !== k) begin
      error_cnt++;
      close_out;
    end
  endtask

  // Pin 1 falls after a settle time, then the core must take it
  task fire(input logic [7:0] k);
    @(posedge i_clk);
    pin1 <= 1'b1;
    repeat (8) @(posedge i_clk);
    pin1 <= 1'b0;
    await_take(k);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rx, tx, ev, mode, pin2, pen, ppri} = '0;
    pin1 = 1'b1;
    error_cnt = 0;
    checked = 0;
    i_rst_b = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    rdc("edge", `IQPF_OFS_EDGE, 32'hf5);
    rdc("pin", `IQPF_OFS_EXTPIN, 32'hc0);
    rdc("flags", `IQPF_OFS_PIRA, 32'h0);
    rdc("core", `IQPF_OFS_CORE, 32'h10);
    $display("test reset done");
    xfer(1'b1, `IQPF_OFS_EDGE, 32'hff);
    rdc("edge", `IQPF_OFS_EDGE, 32'hf5);
    xfer(1'b1, `IQPF_OFS_EXTPIN, 32'hff);
    rdc("pin", `IQPF_OFS_EXTPIN, 32'hd8);
    xfer(1'b1, 12'h020, 32'hff);
    rdc("unmapped", 12'h020, 32'h0);
    xfer(1'b1, `IQPF_OFS_EDGE, 32'h10);
    rdc("edge", `IQPF_OFS_EDGE, 32'h10);
    xfer(1'b1, `IQPF_OFS_EXTPIN, 32'h0);
    $display("test access done");
    pin1 <= 1'b0;
    pin2 <= 1'b1;
    repeat (8) @(posedge i_clk);
    rdc("pin flags", `IQPF_OFS_EXTPIN, 32'h03);
    xfer(1'b1, `IQPF_OFS_EXTPIN, 32'h0);
    rdc("pin clear", `IQPF_OFS_EXTPIN, 32'h0);
    pin1 <= 1'b1;
    pin2 <= 1'b0;
    repeat (8) @(posedge i_clk);
    rdc("wrong edges", `IQPF_OFS_EXTPIN, 32'h0);
    $display("test pins done");
    for (int i = 0; i < 7; i++) begin
      mode <= (i == 2) ? `IQPF_CCP_COMPARE : `IQPF_CCP_CAPTURE;
      pulse(i);
      rdc("periph flag", `IQPF_OFS_PIRA, {24'h0, fexp[i]});
      xfer(1'b1, `IQPF_OFS_PIRA, 32'h0);
    end
    mode <= `IQPF_CCP_PWM;
    pulse(2);
    rdc("pwm match", `IQPF_OFS_PIRA, 32'h0);
    xfer(1'b1, `IQPF_OFS_CORE, 32'h0);
    pulse(6);
    rdc("small variant", `IQPF_OFS_PIRA, 32'h0);
    xfer(1'b1, `IQPF_OFS_PIRA, 32'h0);
    xfer(1'b1, `IQPF_OFS_CORE, 32'h10);
    rx <= 1'b1;
    tx <= 1'b1;
    xfer(1'b1, `IQPF_OFS_PIRA, 32'h0);
    rdc("rx tx set", `IQPF_OFS_PIRA, 32'h30);
    rx <= 1'b0;
    tx <= 1'b0;
    repeat (2) @(posedge i_clk);
    rdc("rx tx clear", `IQPF_OFS_PIRA, 32'h0);
    $display("test peripherals done");
    xfer(1'b1, `IQPF_OFS_EXTPIN, 32'h48);
    xfer(1'b1, `IQPF_OFS_CORE, 32'h15);
    fire(8'h1);
    cmp("high vector", {16'h0, `IQPF_VEC_HIGH}, {16'h0, tvec});
    rdc("core high", `IQPF_OFS_CORE, 32'h14);
    xfer(1'b1, `IQPF_OFS_EXTPIN, 32'h08);
    xfer(1'b1, `IQPF_OFS_CORE, 32'h17);
    fire(8'h2);
    cmp("low vector", {16'h0, `IQPF_VEC_LOW}, {16'h0, tvec});
    rdc("core low", `IQPF_OFS_CORE, 32'h15);
    xfer(1'b1, `IQPF_OFS_EXTPIN, 32'h08);
    xfer(1'b1, `IQPF_OFS_CORE, 32'h11);
    fire(8'h3);
    cmp("compat vector", {16'h0, `IQPF_VEC_HIGH}, {16'h0, tvec});
    rdc("core compat", `IQPF_OFS_CORE, 32'h10);
    pen <= 8'h02;
    xfer(1'b1, `IQPF_OFS_EXTPIN, 32'h0);
    xfer(1'b1, `IQPF_OFS_CORE, 32'h17);
    pulse(1);
    await_take(8'h4);
    cmp("periph low", {16'h0, `IQPF_VEC_LOW}, {16'h0, tvec});
    rdc("vector status", `IQPF_OFS_VECT, 32'h18);
    ppri <= 8'h02;
    await_take(8'h5);
    cmp("periph high", {16'h0, `IQPF_VEC_HIGH}, {16'h0, tvec});
    rdc("core periph", `IQPF_OFS_CORE, 32'h14);
    $display("test vectoring done");
    close_out;
  end
endmodule
`default_nettype wire
